// ===== rgp_pkg.sv
// Constants, codes and decode helpers for the third-pin function
// mux and the I/O port register. Assumes an AXI4-Lite register bus
// with 32-bit data and 8-bit byte addresses.
//
// Behaviour
// - Bits 4:0 pick pin-2 function; 11101 drives high, 00111, 01000, 01001, 01110 release the pin, other unlisted codes drive low.
// - 00000 outputs the controller clock; 00001 shows wake timer expiry.
// - 00010 drives high while supply is below the low-battery threshold.
// - 00011 makes a direct input; 01010 a direct output from the port bit.
// - 00100 and 00101 make falling and rising edge interrupt inputs.
// - 00110 makes an interrupt input that fires on any level change.
// - 01111 outputs the receive bit clock, 10100 the receive data.
// - 10001 makes the pin a retransmission request input.
// - 10101 outputs receive state, 10110 receive buffer almost full.
// - 10111 and 11000 output the two antenna switch controls.
// - 11001 and 11010 output valid and invalid preamble detected.
// - 11011 outputs sync word detected, 11100 clear channel result.
// - Bits 7:6 of the pin config select the drive strength.
// - Bit 5 enables the pull-up only while the pin is a digital input.
// - Bits 6:4 are read-only interrupt status flags of the three pins.
// - Port bit 3 with chip select high puts the interrupt on serial out.
// - Direct outputs follow port bits 2, 1, 0 for pins 2, 1, 0.
// - Reading a direct input's port bit returns the pin's present level.
package rgp_pkg;
  localparam int ADDR_W = 8;
  localparam logic [5:0] IDX_PIN2_CFG = 6'h0D;
  localparam logic [5:0] IDX_IO_PORT = 6'h0E;
  localparam logic [7:0] PIN2_CFG_RST = 8'h00;
  localparam logic [3:0] IO_PORT_RST = 4'h0;
  localparam int DRV_LO = 6;
  localparam int PUP_BIT = 5;
  localparam int ITSDO_BIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [4:0] F_MCU_CLK = 5'h00;
  localparam logic [4:0] F_WAKE = 5'h01;
  localparam logic [4:0] F_LOW_BATT = 5'h02;
  localparam logic [4:0] F_DIN = 5'h03;
  localparam logic [4:0] F_IRQ_FALL = 5'h04;
  localparam logic [4:0] F_IRQ_RISE = 5'h05;
  localparam logic [4:0] F_IRQ_CHG = 5'h06;
  localparam logic [4:0] F_ADC_IN = 5'h07;
  localparam logic [4:0] F_TEST_N = 5'h08;
  localparam logic [4:0] F_TEST_P = 5'h09;
  localparam logic [4:0] F_DOUT = 5'h0A;
  localparam logic [4:0] F_VREF = 5'h0E;
  localparam logic [4:0] F_RX_CLK = 5'h0F;
  localparam logic [4:0] F_RETX = 5'h11;
  localparam logic [4:0] F_RX_DATA = 5'h14;
  localparam logic [4:0] F_RX_STATE = 5'h15;
  localparam logic [4:0] F_AFULL = 5'h16;
  localparam logic [4:0] F_ANT1 = 5'h17;
  localparam logic [4:0] F_ANT2 = 5'h18;
  localparam logic [4:0] F_PRE_OK = 5'h19;
  localparam logic [4:0] F_PRE_BAD = 5'h1A;
  localparam logic [4:0] F_SYNC = 5'h1B;
  localparam logic [4:0] F_CCA = 5'h1C;
  localparam logic [4:0] F_VDD = 5'h1D;

  // Any mode in which the pin is sampled as a digital input
  function automatic logic fsel_is_input(input logic [4:0] code);
    return (code == F_DIN) || (code == F_IRQ_FALL) || (code == F_IRQ_RISE)
        || (code == F_IRQ_CHG) || (code == F_RETX);
  endfunction

  // Interrupt event for one pin from previous and present samples
  function automatic logic fsel_irq_hit(input logic [4:0] code,
                                        input logic prev,
                                        input logic cur);
    case (code)
      F_IRQ_FALL: return prev & ~cur;
      F_IRQ_RISE: return ~prev & cur;
      F_IRQ_CHG: return prev ^ cur;
      default: return 1'b0;
    endcase
  endfunction
endpackage

// ===== rgp_port.sv
// Third-pin function mux, pin control outputs and the I/O port register,
// behind an AXI4-Lite slave. Pins 0 and 1 take their function codes from
// configuration held elsewhere; radio status arrives as synchronous levels.
`timescale 1ns/100ps
module rgp_port
  import rgp_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Pins and function codes of pins 0 and 1
  input wire logic [2:0] gpio_in,
  input wire logic [4:0] pin0_function_sel_in,
  input wire logic [4:0] pin1_function_sel_in,
  // Internal sources for the pin-2 mux
  input wire logic mcu_clk_in,
  input wire logic wake_timer_expired_in,
  input wire logic low_batt_in,
  input wire logic rx_bit_clk_in,
  input wire logic rx_data_in,
  input wire logic rx_state_in,
  input wire logic rx_almost_full_in,
  input wire logic ant1_sw_in,
  input wire logic ant2_sw_in,
  input wire logic preamble_valid_in,
  input wire logic preamble_invalid_in,
  input wire logic sync_detected_in,
  input wire logic cca_in,
  // Interrupt request and chip select
  input wire logic irq_request_n_in,
  input wire logic chip_select_n_in,
  // Pin 2 drive
  output logic pin2_out,
  output logic pin2_oe_out,
  output logic pin2_pullup_out,
  output logic [1:0] drive_strength_sel_out,
  // Pins 0 and 1 direct output levels
  output logic direct_io_bit0_out,
  output logic direct_io_bit1_out,
  // Serial data output share
  output logic sdo_irq_out,
  output logic sdo_irq_oe_out,
  // Events toward the radio core
  output logic retx_request_out,
  output logic [2:0] ext_irq_status_out
);

  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic [2:0] prev_r;
  logic [7:0] pin2_cfg_r;
  logic [3:0] io_ctl_r;
  logic [2:0] irq_flag_r;
  logic [2:0] irq_flag_nxt;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [7:0] w_byte_r;
  logic w_lane0_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [31:0] rdata_r;
  logic pin2_r;
  logic pin2_oe_r;
  logic pullup_r;
  logic sdo_r;
  logic sdo_oe_r;
  logic retx_r;

  // Bus decode
  wire aw_fire_w = s_axi_awvalid_in & awready_r;
  wire w_fire_w = s_axi_wvalid_in & wready_r;
  wire b_fire_w = bvalid_r & s_axi_bready_in;
  wire ar_fire_w = s_axi_arvalid_in & arready_r;
  wire r_fire_w = rvalid_r & s_axi_rready_in;
  wire wr_go_w = ~awready_r & ~wready_r & ~bvalid_r;
  wire wr_cfg_w = aw_addr_r[ADDR_W-1:2] == IDX_PIN2_CFG;
  wire wr_io_w = aw_addr_r[ADDR_W-1:2] == IDX_IO_PORT;
  wire rd_cfg_w = s_axi_araddr_in[ADDR_W-1:2] == IDX_PIN2_CFG;
  wire rd_io_w = s_axi_araddr_in[ADDR_W-1:2] == IDX_IO_PORT;
  wire [4:0] fsel2_w = pin2_cfg_r[4:0];
  wire [4:0] fsel1_w = pin1_function_sel_in;
  wire [4:0] fsel0_w = pin0_function_sel_in;

  // Port bit readback: pin level for direct inputs, stored bit otherwise
  wire [2:0] dio_view_w = {
    (fsel2_w == F_DIN) ? sync2_r[2] : io_ctl_r[2],
    (fsel1_w == F_DIN) ? sync2_r[1] : io_ctl_r[1],
    (fsel0_w == F_DIN) ? sync2_r[0] : io_ctl_r[0]};
  wire [7:0] io_view_w = {1'b0, irq_flag_r, io_ctl_r[ITSDO_BIT], dio_view_w};
  wire [7:0] rd_byte_w = rd_cfg_w ? pin2_cfg_r : (rd_io_w ? io_view_w : 8'h00);

  // Edge events of all three pins on synchronised samples
  wire [2:0] irq_hit_w = {
    fsel_irq_hit(fsel2_w, prev_r[2], sync2_r[2]),
    fsel_irq_hit(fsel1_w, prev_r[1], sync2_r[1]),
    fsel_irq_hit(fsel0_w, prev_r[0], sync2_r[0])};
  // Reading the port clears the flags, but a new event in that cycle wins
  wire flag_clr_w = ar_fire_w & rd_io_w;

  assign irq_flag_nxt = irq_hit_w | (irq_flag_r & ~{3{flag_clr_w}});

  // Pin-2 level and direction by function code
  logic pin2_lvl_w;
  logic pin2_oe_w;
  always_comb begin
    pin2_lvl_w = 1'b0;
    pin2_oe_w = 1'b1;
    case (fsel2_w)
      F_MCU_CLK: pin2_lvl_w = mcu_clk_in;
      F_WAKE: pin2_lvl_w = wake_timer_expired_in;
      F_LOW_BATT: pin2_lvl_w = low_batt_in;
      F_DOUT: pin2_lvl_w = io_ctl_r[2];
      F_RX_CLK: pin2_lvl_w = rx_bit_clk_in;
      F_RX_DATA: pin2_lvl_w = rx_data_in;
      F_RX_STATE: pin2_lvl_w = rx_state_in;
      F_AFULL: pin2_lvl_w = rx_almost_full_in;
      F_ANT1: pin2_lvl_w = ant1_sw_in;
      F_ANT2: pin2_lvl_w = ant2_sw_in;
      F_PRE_OK: pin2_lvl_w = preamble_valid_in;
      F_PRE_BAD: pin2_lvl_w = preamble_invalid_in;
      F_SYNC: pin2_lvl_w = sync_detected_in;
      F_CCA: pin2_lvl_w = cca_in;
      F_VDD: pin2_lvl_w = 1'b1;
      // Analog uses are served outside; the digital driver lets go
      F_ADC_IN, F_TEST_N, F_TEST_P, F_VREF: pin2_oe_w = 1'b0;
      default: pin2_oe_w = ~fsel_is_input(fsel2_w);
    endcase
  end

  // Pin input synchronisers; only sync2_r and its delayed copy prev_r feed any logic
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      prev_r <= 3'h0;
    end else if (ce_in) begin
      sync1_r <= gpio_in;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_flag_r <= 3'h0;
    end else if (ce_in) begin
      irq_flag_r <= irq_flag_nxt;
    end
  end

  // Register writes land once both address and data are held
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin2_cfg_r <= PIN2_CFG_RST;
      io_ctl_r <= IO_PORT_RST;
    end else if (ce_in && wr_go_w && w_lane0_r) begin
      if (wr_cfg_w) begin
        pin2_cfg_r <= w_byte_r;
      end
      if (wr_io_w) begin
        io_ctl_r <= w_byte_r[3:0];
      end
    end
  end

  // Write channel: one write in flight, channels taken in any order
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      aw_addr_r <= '0;
      w_byte_r <= 8'h00;
      w_lane0_r <= 1'b0;
    end else if (ce_in) begin
      if (aw_fire_w) begin
        awready_r <= 1'b0;
        aw_addr_r <= s_axi_awaddr_in;
      end
      if (w_fire_w) begin
        wready_r <= 1'b0;
        w_byte_r <= s_axi_wdata_in[7:0];
        w_lane0_r <= s_axi_wstrb_in[0];
      end
      if (wr_go_w) begin
        bvalid_r <= 1'b1;
        bresp_r <= (wr_cfg_w | wr_io_w) ? RESP_OKAY : RESP_SLVERR;
      end
      if (b_fire_w) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  // Read channel: data registered at the address handshake
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else if (ce_in) begin
      if (ar_fire_w) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= {24'h00_0000, rd_byte_w};
        rresp_r <= (rd_cfg_w | rd_io_w) ? RESP_OKAY : RESP_SLVERR;
      end
      if (r_fire_w) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // Pin drive flops; clock and data paths share one delay, so the host's
  // sampling relation between them survives
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin2_r <= 1'b0;
      pin2_oe_r <= 1'b0;
      pullup_r <= 1'b0;
      retx_r <= 1'b0;
    end else if (ce_in) begin
      pin2_r <= pin2_lvl_w;
      pin2_oe_r <= pin2_oe_w;
      pullup_r <= pin2_cfg_r[PUP_BIT] & fsel_is_input(fsel2_w);
      retx_r <= (fsel2_w == F_RETX) & sync2_r[2];
    end
  end

  // Interrupt shares the serial output only while the host is deselected
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sdo_r <= 1'b1;
      sdo_oe_r <= 1'b0;
    end else if (ce_in) begin
      sdo_r <= irq_request_n_in;
      sdo_oe_r <= io_ctl_r[ITSDO_BIT] & chip_select_n_in;
    end
  end

  assign s_axi_awready_out = awready_r;
  assign s_axi_wready_out = wready_r;
  assign s_axi_bvalid_out = bvalid_r;
  assign s_axi_bresp_out = bresp_r;
  assign s_axi_arready_out = arready_r;
  assign s_axi_rvalid_out = rvalid_r;
  assign s_axi_rresp_out = rresp_r;
  assign s_axi_rdata_out = rdata_r;
  assign pin2_out = pin2_r;
  assign pin2_oe_out = pin2_oe_r;
  assign pin2_pullup_out = pullup_r;
  assign drive_strength_sel_out = pin2_cfg_r[DRV_LO+1:DRV_LO];
  assign direct_io_bit0_out = io_ctl_r[0];
  assign direct_io_bit1_out = io_ctl_r[1];
  assign sdo_irq_out = sdo_r;
  assign sdo_irq_oe_out = sdo_oe_r;
  assign retx_request_out = retx_r;
  assign ext_irq_status_out = irq_flag_r;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);

  AST_VDD_HIGH: assert property (
    ce_in && fsel2_w == F_VDD |=> pin2_out && pin2_oe_out)
    else $error("pin 2 not high in supply mode");
  AST_UNLISTED_LOW: assert property (
    ce_in && fsel2_w == 5'h10 |=> !pin2_out && pin2_oe_out)
    else $error("pin 2 not low for unlisted code");
  AST_MCU_CLK: assert property (
    ce_in && fsel2_w == F_MCU_CLK |=> pin2_out == $past(mcu_clk_in))
    else $error("controller clock not on pin 2");
  AST_WAKE: assert property (
    ce_in && fsel2_w == F_WAKE |=> pin2_out == $past(wake_timer_expired_in))
    else $error("wake timer state not on pin 2");
  AST_LOW_BATT: assert property (
    ce_in && fsel2_w == F_LOW_BATT |=> pin2_out == $past(low_batt_in))
    else $error("low battery not on pin 2");
  AST_DOUT: assert property (
    ce_in && fsel2_w == F_DOUT |=> pin2_oe_out && pin2_out == $past(io_ctl_r[2]))
    else $error("direct output does not follow port bit");
  AST_FALL_FLAG: assert property (
    ce_in && fsel2_w == F_IRQ_FALL && prev_r[2] && !sync2_r[2] |=> irq_flag_r[2])
    else $error("falling edge not flagged");
  AST_RISE_FLAG: assert property (
    ce_in && fsel2_w == F_IRQ_RISE && !prev_r[2] && sync2_r[2] |=> irq_flag_r[2])
    else $error("rising edge not flagged");
  AST_CHG_FLAG: assert property (
    ce_in && fsel0_w == F_IRQ_CHG && (prev_r[0] != sync2_r[0]) |=> irq_flag_r[0])
    else $error("level change not flagged");
  AST_RX_CLK: assert property (
    ce_in && fsel2_w == F_RX_CLK |=> pin2_out == $past(rx_bit_clk_in))
    else $error("receive bit clock not on pin 2");
  AST_RX_DATA: assert property (
    ce_in && fsel2_w == F_RX_DATA |=> pin2_out == $past(rx_data_in))
    else $error("receive data not on pin 2");
  AST_RETX: assert property (
    ce_in && fsel2_w == F_RETX |=> !pin2_oe_out && retx_request_out == $past(sync2_r[2]))
    else $error("retransmission request does not follow pin 2");
  AST_RX_STATE: assert property (
    ce_in && fsel2_w == F_RX_STATE |=> pin2_out == $past(rx_state_in))
    else $error("receive state not on pin 2");
  AST_ANT2: assert property (
    ce_in && fsel2_w == F_ANT2 |=> pin2_out == $past(ant2_sw_in))
    else $error("second antenna control not on pin 2");
  AST_PRE_BAD: assert property (
    ce_in && fsel2_w == F_PRE_BAD |=> pin2_out == $past(preamble_invalid_in))
    else $error("invalid preamble not on pin 2");
  AST_CCA: assert property (
    ce_in && fsel2_w == F_CCA |=> pin2_out == $past(cca_in))
    else $error("channel assessment not on pin 2");
  AST_DRIVE: assert property (
    ce_in && wr_go_w && w_lane0_r && wr_cfg_w
    |=> drive_strength_sel_out == $past(w_byte_r[DRV_LO+1:DRV_LO]))
    else $error("drive strength not taken from the written byte");
  AST_FLAG_HOLD: assert property (
    ce_in && irq_flag_r[2] && !flag_clr_w |=> irq_flag_r[2])
    else $error("status flag lost without a read");
  AST_FLAG_CLEAR: assert property (
    ce_in && flag_clr_w && irq_hit_w == 3'h0 |=> irq_flag_r == 3'h0)
    else $error("status flags not cleared by a port read");
  AST_PULLUP: assert property (
    ce_in && !fsel_is_input(fsel2_w) |=> !pin2_pullup_out)
    else $error("pull-up on while not an input");
  AST_SDO_IRQ: assert property (
    ce_in && !chip_select_n_in |=> !sdo_irq_oe_out)
    else $error("interrupt driven on serial out while selected");
  AST_SDO_ON: assert property (
    ce_in && io_ctl_r[ITSDO_BIT] && chip_select_n_in
    |=> sdo_irq_oe_out && sdo_irq_out == $past(irq_request_n_in))
    else $error("interrupt missing on serial out while deselected");
  AST_DIRECT_IO_BIT0: assert property (
    ce_in && wr_go_w && w_lane0_r && wr_io_w |=> direct_io_bit0_out == $past(w_byte_r[0]))
    else $error("pin 0 output does not follow port bit");
  AST_RD_ANSWER: assert property (
    ar_fire_w && ce_in |=> s_axi_rvalid_out[*1] ##0 !s_axi_arready_out)
    else $error("read answer missing");
  AST_DIN_READ: assert property (
    ar_fire_w && ce_in && rd_io_w && fsel1_w == F_DIN |=> s_axi_rdata_out[1] == $past(sync2_r[1]))
    else $error("direct input level not returned");
  AST_SYNC_DELAY: assert property (
    ce_in ##1 ce_in |=> sync2_r == $past(gpio_in, 2))
    else $error("pin synchroniser depth wrong");

  COV_WRITE: cover property (b_fire_w);
  COV_IRQ_READ: cover property (flag_clr_w && irq_flag_r != 3'h0);
  COV_SDO: cover property (sdo_irq_oe_out && !sdo_irq_out);
  COV_RETX: cover property (retx_request_out);
endmodule

// ===== rgp_host.sv
// AXI4-Lite master standing in for the host controller, used through its tasks.
// Assumes one clock; every handshake is judged at a rising edge.
`timescale 1ns/100ps
module rgp_host
  import rgp_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Write channels
  output logic [ADDR_W-1:0] awaddr_out,
  output logic awvalid_out,
  input wire logic awready_in,
  output logic [31:0] wdata_out,
  output logic [3:0] wstrb_out,
  output logic wvalid_out,
  input wire logic wready_in,
  input wire logic [1:0] bresp_in,
  input wire logic bvalid_in,
  output logic bready_out,
  // Read channels
  output logic [ADDR_W-1:0] araddr_out,
  output logic arvalid_out,
  input wire logic arready_in,
  input wire logic [31:0] rdata_in,
  input wire logic [1:0] rresp_in,
  input wire logic rvalid_in,
  output logic rready_out
);
  initial begin
    {awaddr_out, awvalid_out, wdata_out, wvalid_out, bready_out} = '0;
    {araddr_out, arvalid_out, rready_out} = '0;
    wstrb_out = 4'hF;
  end

  // Released payloads show the inverse so a stale value is never mistaken for live
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk_in);
    awaddr_out <= a;
    awvalid_out <= 1'b1;
    wdata_out <= d;
    wvalid_out <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_in);
      if (!aw_ok && awready_in === 1'b1) begin
        aw_ok = 1'b1;
        awvalid_out <= 1'b0;
        awaddr_out <= ~a;
      end
      if (!w_ok && wready_in === 1'b1) begin
        w_ok = 1'b1;
        wvalid_out <= 1'b0;
        wdata_out <= ~d;
      end
    end
    bready_out <= 1'b1;
    do @(posedge clk_in); while (bvalid_in !== 1'b1);
    resp = bresp_in;
    bready_out <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge clk_in);
    araddr_out <= a;
    arvalid_out <= 1'b1;
    do @(posedge clk_in); while (arready_in !== 1'b1);
    arvalid_out <= 1'b0;
    araddr_out <= ~a;
    rready_out <= 1'b1;
    do @(posedge clk_in); while (rvalid_in !== 1'b1);
    d = rdata_in;
    resp = rresp_in;
    rready_out <= 1'b0;
  endtask
endmodule

// ===== tb_top.sv
// Self-checking bench for the pin-2 mux and I/O port register.
// Assumes the host model drives the register bus; pins and sources come from here.
`timescale 1ns/100ps
module tb_top
  import rgp_pkg::*;
;
  localparam logic [7:0] A_CFG = {IDX_PIN2_CFG, 2'b00};
  localparam logic [7:0] A_PORT = {IDX_IO_PORT, 2'b00};
  localparam logic [4:0] MUXC [13] = '{F_MCU_CLK, F_WAKE, F_LOW_BATT, F_RX_CLK, F_RX_DATA,
    F_RX_STATE, F_AFULL, F_ANT1, F_ANT2, F_PRE_OK, F_PRE_BAD, F_SYNC, F_CCA};
  logic clk_sys_in, rstn_in, cs_n, irq_n;
  logic [2:0] gpio_in;
  logic [4:0] p0_sel, p1_sel;
  logic [12:0] src;
  logic [7:0] aw_a, ar_a;
  logic [31:0] w_d, r_d, rdat;
  logic [3:0] w_s;
  logic [1:0] b_rs, r_rs, resp;
  logic aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
  logic ce, g2, g2_oe, pup, io0, io1, sdo, sdo_oe, retx;
  logic [1:0] drv;
  logic [2:0] flags;
  int n_fail = 0;
  int checked = 0;

  rgp_host u_host (.clk_in(clk_sys_in), .awaddr_out(aw_a), .awvalid_out(aw_v),
    .awready_in(aw_r), .wdata_out(w_d), .wstrb_out(w_s), .wvalid_out(w_v), .wready_in(w_r),
    .bresp_in(b_rs), .bvalid_in(b_v), .bready_out(b_r), .araddr_out(ar_a), .arvalid_out(ar_v),
    .arready_in(ar_r), .rdata_in(r_d), .rresp_in(r_rs), .rvalid_in(r_v), .rready_out(r_r));

  rgp_port u_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .ce_in(ce),
    .s_axi_awaddr_in(aw_a), .s_axi_awvalid_in(aw_v), .s_axi_awready_out(aw_r),
    .s_axi_wdata_in(w_d), .s_axi_wstrb_in(w_s), .s_axi_wvalid_in(w_v), .s_axi_wready_out(w_r),
    .s_axi_bresp_out(b_rs), .s_axi_bvalid_out(b_v), .s_axi_bready_in(b_r),
    .s_axi_araddr_in(ar_a), .s_axi_arvalid_in(ar_v), .s_axi_arready_out(ar_r),
    .s_axi_rdata_out(r_d), .s_axi_rresp_out(r_rs), .s_axi_rvalid_out(r_v), .s_axi_rready_in(r_r),
    .gpio_in(gpio_in), .pin0_function_sel_in(p0_sel), .pin1_function_sel_in(p1_sel),
    .mcu_clk_in(src[0]), .wake_timer_expired_in(src[1]), .low_batt_in(src[2]),
    .rx_bit_clk_in(src[3]), .rx_data_in(src[4]), .rx_state_in(src[5]),
    .rx_almost_full_in(src[6]), .ant1_sw_in(src[7]), .ant2_sw_in(src[8]),
    .preamble_valid_in(src[9]), .preamble_invalid_in(src[10]), .sync_detected_in(src[11]),
    .cca_in(src[12]), .irq_request_n_in(irq_n), .chip_select_n_in(cs_n),
    .pin2_out(g2), .pin2_oe_out(g2_oe), .pin2_pullup_out(pup), .drive_strength_sel_out(drv),
    .direct_io_bit0_out(io0), .direct_io_bit1_out(io1), .sdo_irq_out(sdo),
    .sdo_irq_oe_out(sdo_oe), .retx_request_out(retx), .ext_irq_status_out(flags));

  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Checks land 1 ns past the edge so flop updates have settled
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask

  task automatic wcfg(input logic [7:0] v);
    u_host.wr(A_CFG, {24'h0, v}, resp);
    check({30'h0, resp}, {30'h0, RESP_OKAY});
  endtask

  task automatic irq_step(input logic [4:0] code, input logic lvl, input logic exp);
    wcfg({3'h0, code});
    u_host.rd(A_PORT, rdat, resp);
    @(posedge clk_sys_in);
    gpio_in[2] <= lvl;
    idle(5);
    check({31'h0, flags[2]}, {31'h0, exp});
    u_host.rd(A_PORT, rdat, resp);
    check({31'h0, rdat[6]}, {31'h0, exp});
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_fail++;
    tally_and_finish();
  end

  initial begin
    rstn_in = 1'b0;
    {cs_n, irq_n, gpio_in, src} = '0;
    cs_n = 1'b1;
    ce = 1'b1;
    p0_sel = F_DOUT;
    p1_sel = F_DOUT;
    repeat (6) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    u_host.rd(A_CFG, rdat, resp);
    check(rdat, {24'h0, PIN2_CFG_RST});
    u_host.rd(A_PORT, rdat, resp);
    check(rdat, {28'h0, IO_PORT_RST});
    u_host.rd(8'h3C, rdat, resp);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    u_host.wr(8'h3C, 32'hFF, resp);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    for (int k = 0; k < 13; k++) begin
      wcfg({3'h0, MUXC[k]});
      @(posedge clk_sys_in);
      src <= 13'h1 << k;
      idle(3);
      check({30'h0, g2_oe, g2}, 32'h3);
      @(posedge clk_sys_in);
      src <= ~(13'h1 << k);
      idle(3);
      check({30'h0, g2_oe, g2}, 32'h2);
    end
    wcfg({3'h0, F_VDD});
    idle(2);
    check({30'h0, g2_oe, g2}, 32'h3);
    wcfg(8'h10);
    idle(2);
    check({30'h0, g2_oe, g2}, 32'h2);
    wcfg({3'h0, F_ADC_IN});
    idle(2);
    check({30'h0, g2_oe, g2}, 32'h0);
    wcfg(8'hE3);
    idle(2);
    check({29'h0, drv, pup}, 32'h7);
    check({31'h0, g2_oe}, 32'h0);
    wcfg(8'hA0);
    idle(2);
    check({29'h0, drv, pup}, 32'h4);
    wcfg({3'h0, F_DOUT});
    u_host.wr(A_PORT, 32'hFF, resp);
    idle(2);
    check({28'h0, g2_oe, g2, io1, io0}, 32'hF);
    check({30'h0, sdo_oe, sdo}, 32'h2);
    u_host.rd(A_PORT, rdat, resp);
    check(rdat, 32'h0F);
    @(posedge clk_sys_in);
    cs_n <= 1'b0;
    irq_n <= 1'b1;
    idle(3);
    check({30'h0, sdo_oe, sdo}, 32'h1);
    u_host.wr(A_PORT, 32'h0A, resp);
    idle(2);
    check({29'h0, g2, io1, io0}, 32'h2);
    @(posedge clk_sys_in);
    p1_sel <= F_DIN;
    gpio_in <= 3'b001;
    wcfg({3'h0, F_DIN});
    idle(4);
    u_host.rd(A_PORT, rdat, resp);
    check(rdat, 32'h08);
    irq_step(F_IRQ_FALL, 1'b1, 1'b0);
    irq_step(F_IRQ_FALL, 1'b0, 1'b1);
    irq_step(F_IRQ_RISE, 1'b1, 1'b1);
    irq_step(F_IRQ_RISE, 1'b0, 1'b0);
    irq_step(F_IRQ_CHG, 1'b1, 1'b1);
    irq_step(F_IRQ_CHG, 1'b0, 1'b1);
    @(posedge clk_sys_in);
    p0_sel <= F_IRQ_CHG;
    idle(4);
    u_host.rd(A_PORT, rdat, resp);
    @(posedge clk_sys_in);
    gpio_in[0] <= 1'b0;
    idle(5);
    u_host.rd(A_PORT, rdat, resp);
    check({29'h0, rdat[6:4]}, 32'h1);
    wcfg({3'h0, F_RETX});
    @(posedge clk_sys_in);
    gpio_in[2] <= 1'b1;
    idle(4);
    check({30'h0, g2_oe, retx}, 32'h1);
    @(posedge clk_sys_in);
    gpio_in[2] <= 1'b0;
    idle(4);
    check({31'h0, retx}, 32'h0);
    // Enable low must freeze the synchroniser and the request flop
    @(posedge clk_sys_in);
    ce <= 1'b0;
    gpio_in[2] <= 1'b1;
    idle(4);
    check({31'h0, retx}, 32'h0);
    @(posedge clk_sys_in);
    ce <= 1'b1;
    idle(4);
    check({31'h0, retx}, 32'h1);
    tally_and_finish();
  end
endmodule
